// *** hw/flpp_ctrl.sv ***
// flpp_ctrl: flash program / erase sequencer with block protection
// assumes an 8-bit Avalon-MM master and an array answering reads in one cycle
//
// How it works
// - an erased array byte reads back as zero
// - programming works on one byte at a time
// - program select arms capture of next array address and data
// - margin mode reads take eight extra bus cycles
// - unrelated bus traffic between steps keeps the operation alive
// - reading the protect byte captures it for the range check
// - locked target clears program or erase select, blocking hv
// - protect byte of zeros leaves the whole array open
// - bits three and two lock from 7A00 or 7900 plus vectors
// - bits one and zero lock from 7880 or 7800 plus vectors
// - several protect bits lock the union of their ranges
// - test high voltage on the pin bypasses all protection
// - the protect byte lives in the array at FFF0
// - margin select is refused and dropped while hv is on
// - program and erase select are never both set
// - pump divider zero gives bus clock, one gives half
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module flpp_ctrl #(
  parameter logic [3:0] P_MARGIN_EXTRA = flpp_pkg::MARGIN_EXTRA
) (
  // clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // avalon-mm slave
  input  wire logic [15:0] i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [7:0]  i_avs_writedata,
  output logic [7:0]       o_avs_readdata,
  output logic             o_avs_waitrequest,
  // test voltage detect pin
  input  wire logic        i_test_high_voltage,
  // array read port
  output logic             o_arr_rd,
  output logic [15:0]      o_arr_addr,
  input  wire logic [7:0]  i_arr_rdata,
  // array program / erase control
  output logic             o_program_select,
  output logic             o_erase_select,
  output logic [1:0]       o_erase_blk,
  output logic             o_margin_read,
  output logic             o_high_voltage_enable,
  output logic             o_pump_clk_en,
  output logic [15:0]      o_pgm_addr,
  output logic [7:0]       o_pgm_data
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    flpp_pkg::flpp_fsm_t st;
    logic                wreq;
    logic [7:0]          rdata;
    logic [15:0]         raddr;
    logic                rd_strb;
    logic                rd_dly;
    logic [3:0]          cnt;
    logic                program_select;
    logic                ers;
    logic                mrg;
    logic                high_voltage_enable;
    logic                blk0;
    logic                blk1;
    logic                fdiv;
    logic                adr_v;
    logic [15:0]         cap_addr;
    logic [7:0]          cap_data;
    logic                prot_v;
    logic [3:0]          prot;
    logic                pump;
  } flpp_st_t;

  localparam flpp_st_t ST_RST = '{
    st:      flpp_pkg::S_IDLE,
    wreq:    1'b1,
    rdata:   flpp_pkg::UNMAPPED_RD,
    raddr:   16'h0000,
    cnt:     4'h0,
    cap_addr: 16'h0000,
    cap_data: 8'h00,
    prot:    4'h0,
    default: 1'b0
  };

  flpp_st_t r;
  flpp_st_t n;

  logic       tst_hv;
  logic       locked;
  logic [7:0] ctrl_rd;
  logic       wr_p;
  logic       wr_e;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_ctrl(input logic [15:0] a);
    return a == flpp_pkg::CTRL_ADDR;
  endfunction

  function automatic logic selected(input logic p, input logic e);
    return p || e;
  endfunction

  // pump divide by one or two
  function automatic logic pump_next(input logic hv, input logic div, input logic cur);
    if (!hv) begin
      return 1'b0;
    end
    return div ? !cur : 1'b1;
  endfunction

  // ****************************************
  // pin synchroniser
  // ****************************************
  flpp_sync3 u_tst_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_pin   (i_test_high_voltage),
    .o_level (tst_hv)
  );

  // ****************************************
  // protection check
  // ****************************************
  flpp_prot_chk u_prot (
    .i_prot   (r.prot),
    .i_bypass (tst_hv),
    .i_addr   (r.cap_addr),
    .i_erase  (r.ers),
    .i_blk    ({r.blk1, r.blk0}),
    .o_locked (locked)
  );

  // ****************************************
  // control readback
  // ****************************************
  always_comb begin
    ctrl_rd                   = 8'h00;
    ctrl_rd[flpp_pkg::B_PGM]  = r.program_select;
    ctrl_rd[flpp_pkg::B_ERS]  = r.ers;
    ctrl_rd[flpp_pkg::B_MRG]  = r.mrg;
    ctrl_rd[flpp_pkg::B_HV]   = r.high_voltage_enable;
    ctrl_rd[flpp_pkg::B_BLK0] = r.blk0;
    ctrl_rd[flpp_pkg::B_BLK1] = r.blk1;
    ctrl_rd[flpp_pkg::B_FDIV] = r.fdiv;
  end

  assign wr_p = i_avs_writedata[flpp_pkg::B_PGM];
  assign wr_e = i_avs_writedata[flpp_pkg::B_ERS];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n         = r;
    n.rd_strb = 1'b0;
    n.rd_dly  = r.rd_strb;

    case (r.st)
      flpp_pkg::S_IDLE: begin
        if (i_avs_write) begin
          if (is_ctrl(i_avs_address)) begin
            if (!(wr_p && wr_e)) begin
              n.program_select = wr_p;
              n.ers = wr_e;
            end
            n.blk0 = i_avs_writedata[flpp_pkg::B_BLK0];
            n.blk1 = i_avs_writedata[flpp_pkg::B_BLK1];
            n.fdiv = i_avs_writedata[flpp_pkg::B_FDIV];
            // hv only for an open target
            if (i_avs_writedata[flpp_pkg::B_HV]) begin
              n.high_voltage_enable = selected(n.program_select, n.ers) && r.prot_v
                       && r.adr_v && !locked;
            end else begin
              n.high_voltage_enable = 1'b0;
            end
            n.mrg = i_avs_writedata[flpp_pkg::B_MRG]
                    && !r.high_voltage_enable && !n.high_voltage_enable;
          end else if (flpp_pkg::in_array(i_avs_address)) begin
            if (selected(r.program_select, r.ers) && !r.adr_v) begin
              n.cap_addr = i_avs_address;
              n.cap_data = i_avs_writedata;
              n.adr_v    = 1'b1;
            end
          end
          n.wreq = 1'b0;
          n.st   = flpp_pkg::S_ACK;
        end else if (i_avs_read) begin
          if (is_ctrl(i_avs_address)) begin
            n.rdata = ctrl_rd;
            n.wreq  = 1'b0;
            n.st    = flpp_pkg::S_ACK;
          end else if (flpp_pkg::in_array(i_avs_address)) begin
            n.raddr   = i_avs_address;
            n.rd_strb = 1'b1;
            if (r.mrg) begin
              n.cnt = 4'(flpp_pkg::RD_LAT + P_MARGIN_EXTRA);
            end else begin
              n.cnt = flpp_pkg::RD_LAT;
            end
            n.st = flpp_pkg::S_ARR;
          end else begin
            n.rdata = flpp_pkg::UNMAPPED_RD;
            n.wreq  = 1'b0;
            n.st    = flpp_pkg::S_ACK;
          end
        end
      end

      flpp_pkg::S_ARR: begin
        // array data stand only the cycle after the strobe
        if (r.rd_dly) begin
          n.rdata = i_arr_rdata;
          if (r.raddr == flpp_pkg::PROT_ADDR) begin
            n.prot   = i_arr_rdata[3:0];
            n.prot_v = 1'b1;
          end
        end
        if (r.cnt == 4'h0) begin
          n.wreq = 1'b0;
          n.st   = flpp_pkg::S_ACK;
        end else begin
          n.cnt = r.cnt - 4'h1;
        end
      end

      flpp_pkg::S_ACK: begin
        n.wreq = 1'b1;
        n.st   = flpp_pkg::S_IDLE;
      end

      default: begin
        n.wreq = 1'b1;
        n.st   = flpp_pkg::S_IDLE;
      end
    endcase

    if (selected(r.program_select, r.ers) && r.prot_v && r.adr_v && locked) begin
      n.program_select  = 1'b0;
      n.ers  = 1'b0;
      n.high_voltage_enable = 1'b0;
    end

    if (!selected(n.program_select, n.ers)) begin
      n.high_voltage_enable   = 1'b0;
      n.adr_v  = 1'b0;
      n.prot_v = 1'b0;
    end

    if (n.high_voltage_enable) begin
      n.mrg = 1'b0;
    end

    // pump follows hv in the same cycle
    n.pump = pump_next(n.high_voltage_enable, n.fdiv, r.pump);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= ST_RST;
    end else if (i_ce) begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_avs_readdata        = r.rdata;
  assign o_avs_waitrequest     = r.wreq;
  assign o_arr_rd              = r.rd_strb;
  assign o_arr_addr            = r.raddr;
  assign o_program_select      = r.program_select;
  assign o_erase_select        = r.ers;
  assign o_erase_blk           = {r.blk1, r.blk0};
  assign o_margin_read         = r.mrg;
  assign o_high_voltage_enable = r.high_voltage_enable;
  assign o_pump_clk_en         = r.pump;
  assign o_pgm_addr            = r.cap_addr;
  assign o_pgm_data            = r.cap_data;

endmodule // flpp_ctrl

// *** include/flpp_pkg.sv ***
// flpp_pkg: addresses, control fields, reset values, state types
// assumes a 16-bit byte address space and an 8-bit data path
package flpp_pkg;

  // ****************************************
  // address map
  // ****************************************
  localparam logic [15:0] CTRL_ADDR = 16'hFE08;
  localparam logic [15:0] PROT_ADDR = 16'hFFF0;
  localparam logic [15:0] USER_LO   = 16'h7800;
  localparam logic [15:0] USER_HI   = 16'h7FEF;
  localparam logic [15:0] ARR_HI    = 16'h7FFF;
  localparam logic [15:0] VEC_LO    = 16'hFFF0;

  // lowest locked address per protect bit
  localparam logic [15:0] PROT_LO0  = 16'h7800;
  localparam logic [15:0] PROT_LO1  = 16'h7880;
  localparam logic [15:0] PROT_LO2  = 16'h7900;
  localparam logic [15:0] PROT_LO3  = 16'h7A00;

  // erase block masks (cared address bits cleared)
  localparam logic [15:0] BLK_HALF  = 16'h03FF;
  localparam logic [15:0] BLK_EIGHT = 16'h003F;
  localparam logic [15:0] BLK_ROW   = 16'h0007;

  // ****************************************
  // control register fields and values
  // ****************************************
  localparam int B_PGM  = 0;
  localparam int B_ERS  = 1;
  localparam int B_MRG  = 2;
  localparam int B_HV   = 3;
  localparam int B_BLK0 = 4;
  localparam int B_BLK1 = 5;
  localparam int B_FDIV = 6;

  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // ****************************************
  // timing counts in bus cycles
  // ****************************************
  localparam logic [3:0] RD_LAT       = 4'h1;
  localparam logic [3:0] MARGIN_EXTRA = 4'h8;

  // ****************************************
  // decode and types
  // ****************************************
  function automatic logic in_array(input logic [15:0] a);
    return ((a >= USER_LO) && (a <= ARR_HI)) || (a >= VEC_LO);
  endfunction

  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_ARR  = 3'h2,
    S_ACK  = 3'h4
  } flpp_fsm_t;

endpackage

// *** hw/flpp_sync3.sv ***
// flpp_sync3: three-stage synchroniser for an asynchronous pin level
// assumes a slow level input; output moves when stages two and three agree
`timescale 1ns/1ns
module flpp_sync3 (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // pin in, level out
  input  wire logic i_pin,
  output logic      o_level
);

  typedef struct packed {
    logic q1;
    logic q2;
    logic q3;
    logic lvl;
  } flpp_sync_t;

  flpp_sync_t r;
  flpp_sync_t nxt;

  // ****************************************
  // stages
  // ****************************************
  always_comb begin
    nxt    = r;
    nxt.q1 = i_pin;
    nxt.q2 = r.q1;
    nxt.q3 = r.q2;
    if (r.q2 == r.q3) begin
      nxt.lvl = r.q3;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
    end else if (i_ce) begin
      r <= nxt;
    end
  end

  assign o_level = r.lvl;

endmodule // flpp_sync3

// *** hw/flpp_prot_chk.sv ***
// flpp_prot_chk: decides whether a pending program or erase is locked
// assumes a captured protect byte and a captured target address
`timescale 1ns/1ns
module flpp_prot_chk (
  // protect state
  input  wire logic [3:0]  i_prot,
  input  wire logic        i_bypass,
  // pending operation
  input  wire logic [15:0] i_addr,
  input  wire logic        i_erase,
  input  wire logic [1:0]  i_blk,
  // verdict
  output logic             o_locked
);

  logic [15:0] lo;
  logic [15:0] mask;
  logic [15:0] base;
  logic [15:0] top;

  always_comb begin
    if (i_prot[0]) lo = flpp_pkg::PROT_LO0;
    else if (i_prot[1]) lo = flpp_pkg::PROT_LO1;
    else if (i_prot[2]) lo = flpp_pkg::PROT_LO2;
    else lo = flpp_pkg::PROT_LO3;
    case (i_blk)
      2'h1:    mask = flpp_pkg::BLK_HALF;
      2'h2:    mask = flpp_pkg::BLK_EIGHT;
      2'h3:    mask = flpp_pkg::BLK_ROW;
      default: mask = 16'h0000;
    endcase
    if (!i_erase) mask = 16'h0000;
    base = i_addr & ~mask;
    top  = i_addr | mask;
    if (i_bypass) o_locked = 1'b0;
    else if (i_prot == 4'h0) o_locked = 1'b0;
    else if (i_addr >= flpp_pkg::VEC_LO) o_locked = 1'b1;
    else if (i_erase && (i_blk == 2'h0)) o_locked = 1'b1;
    else o_locked = (top >= lo) && (base <= flpp_pkg::USER_HI);
  end

endmodule // flpp_prot_chk

// *** bench/flpp_flash_model.sv ***
// flpp_flash_model: byte array answering the sequencer's reads and programs
// assumes one read strobe per request and data wanted the cycle after it
`timescale 1ns/1ns
module flpp_flash_model (
  // clock
  input  wire logic        i_mclk,
  // read port
  input  wire logic        i_arr_rd,
  input  wire logic [15:0] i_arr_addr,
  output logic [7:0]       o_rdata,
  // program control
  input  wire logic        i_hv,
  input  wire logic        i_pgm,
  input  wire logic [15:0] i_pgm_addr,
  input  wire logic [7:0]  i_pgm_data
);
  // ****************************************
  // cells
  // ****************************************
  logic [7:0] mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    o_rdata = 8'h00;
  end

  // protect byte in array, byte programming
  always @(posedge i_mclk) begin
    if (i_arr_rd) o_rdata <= mem[i_arr_addr];
    else o_rdata <= ~o_rdata;
    if (i_hv && i_pgm) mem[i_pgm_addr] <= mem[i_pgm_addr] | i_pgm_data;
  end
endmodule // flpp_flash_model

// *** bench/flpp_ctrl_props.sv ***
// flpp_ctrl_props: port assertions for the sequencer
// assumes binding into flpp_ctrl, one clock domain
`timescale 1ns/1ns
module flpp_ctrl_props #(
  parameter logic [3:0] P_MARGIN_EXTRA = flpp_pkg::MARGIN_EXTRA
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic o_avs_waitrequest,
  input wire logic o_arr_rd,
  input wire logic o_program_select,
  input wire logic o_erase_select,
  input wire logic o_margin_read,
  input wire logic o_high_voltage_enable,
  input wire logic o_pump_clk_en
);
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_sel_interlock: assert property (!(o_program_select && o_erase_select))
    else $error("program and erase select both set");
  a_hv_needs_sel: assert property (o_high_voltage_enable |-> (o_program_select || o_erase_select))
    else $error("hv on without a select");
  a_margin_hv: assert property (o_high_voltage_enable |-> !o_margin_read)
    else $error("margin set while hv on");
  a_pump_off: assert property (!o_high_voltage_enable |-> !o_pump_clk_en)
    else $error("pump clock runs with hv off");
  a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rd_normal: assert property (o_arr_rd && !o_margin_read && i_ce |-> ##1 o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("normal read answer misplaced");
  a_rd_margin: assert property (o_arr_rd && o_margin_read && i_ce |->
    ##1 o_avs_waitrequest[*8] ##1 o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("margin read not stretched by eight");
  a_reset_clear: assert property ($rose(i_rst_n) |-> !o_program_select && !o_erase_select && !o_margin_read
    && !o_high_voltage_enable)
    else $error("selects set after reset");

  c_hv_pgm: cover property (o_high_voltage_enable && o_program_select);
  c_margin_rd: cover property (o_arr_rd && o_margin_read);
  c_pump_on: cover property (o_pump_clk_en);
endmodule // flpp_ctrl_props

bind flpp_ctrl flpp_ctrl_props #(.P_MARGIN_EXTRA(P_MARGIN_EXTRA)) u_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .o_avs_waitrequest(o_avs_waitrequest),
  .o_arr_rd(o_arr_rd), .o_program_select(o_program_select), .o_erase_select(o_erase_select),
  .o_margin_read(o_margin_read), .o_high_voltage_enable(o_high_voltage_enable), .o_pump_clk_en(o_pump_clk_en)
);

// *** bench/flash_program_protect_ctrl_tb_top.sv ***
// flash_program_protect_ctrl_tb_top: self-checking bench for flpp_ctrl
// assumes the flash model answers array reads and programs on hv
`timescale 1ns/1ns
module flash_program_protect_ctrl_tb_top;
  // ****************************************
  // signals
  // ****************************************
  logic        clk, rst_n, tvh, rd, wr, wtr, ard, psel, esel, mrg, hv, pump;
  logic [15:0] addr, aaddr, paddr, ta;
  logic [7:0]  wdat, rdat, ardat, pdat, q, d;
  logic [1:0]  blk;
  logic [31:0] seed;
  int          n_fail, num_checks, cyc;
  localparam logic [15:0] CTRL = flpp_pkg::CTRL_ADDR;
  localparam logic [15:0] LO [0:3] = '{flpp_pkg::PROT_LO0, flpp_pkg::PROT_LO1, flpp_pkg::PROT_LO2,
                                        flpp_pkg::PROT_LO3};

  flpp_ctrl dut (
    .i_mclk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wtr),
    .i_test_high_voltage(tvh), .o_arr_rd(ard), .o_arr_addr(aaddr), .i_arr_rdata(ardat),
    .o_program_select(psel), .o_erase_select(esel), .o_erase_blk(blk), .o_margin_read(mrg),
    .o_high_voltage_enable(hv), .o_pump_clk_en(pump), .o_pgm_addr(paddr), .o_pgm_data(pdat)
  );
  flpp_flash_model mdl (
    .i_mclk(clk), .i_arr_rd(ard), .i_arr_addr(aaddr), .o_rdata(ardat), .i_hv(hv), .i_pgm(psel),
    .i_pgm_addr(paddr), .i_pgm_data(pdat)
  );

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic locked(input logic [7:0] p, input logic [15:0] a, input logic [7:0] sel);
    logic [15:0] lo;
    logic [15:0] m;
    lo = 16'h0000;
    for (int b = 3; b >= 0; b--) if (p[b]) lo = LO[b];
    case (sel[5:4])
      2'h1:    m = flpp_pkg::BLK_HALF;
      2'h2:    m = flpp_pkg::BLK_EIGHT;
      2'h3:    m = flpp_pkg::BLK_ROW;
      default: m = 16'hFFFF;
    endcase
    if (!sel[1]) m = 16'h0000;
    if (p[3:0] == 4'h0) return 1'b0;
    return (((a | m) >= lo) && ((a & ~m) <= flpp_pkg::USER_HI)) || (a >= flpp_pkg::VEC_LO);
  endfunction

  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] dv);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdat <= dv;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wtr !== 1'b0 && n < 100);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 100) n_fail++;
  endtask

  task automatic try_prot(input logic [7:0] p, input logic [15:0] a, input logic byp, input logic [7:0] sel);
    logic ok;
    ok = byp || !locked(p, a, sel);
    mdl.mem[flpp_pkg::PROT_ADDR] = p;
    // select, protect read, target, then hv
    bus(1, CTRL, sel);
    bus(0, flpp_pkg::PROT_ADDR, 8'h00);
    bus(1, a, 8'h5A);
    bus(0, CTRL, 8'h00);
    chk_val({14'h0, q[1:0]}, ok ? {14'h0, sel[1:0]} : 16'h0000);
    bus(1, CTRL, sel | 8'h08);
    bus(0, CTRL, 8'h00);
    chk_val({15'h0, q[3]}, {15'h0, ok});
    chk_val({15'h0, pump}, {15'h0, ok});
    bus(1, CTRL, 8'h00);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {rd, wr, tvh} = 3'h0;
    addr = 16'h0000;
    wdat = 8'h00;
    {n_fail, num_checks, cyc} = '0;
    seed = 32'd62127;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, CTRL, 8'h00);
    chk_val(q, 8'h00);
    bus(0, 16'h1234, 8'h00);
    chk_val(q, flpp_pkg::UNMAPPED_RD);
    bus(0, 16'h7C00, 8'h00);
    chk_val(q, flpp_pkg::ERASED_BYTE);
    bus(1, CTRL, 8'h03);
    bus(0, CTRL, 8'h00);
    chk_val(q[1:0], 2'h0);
    bus(1, CTRL, 8'h02);
    bus(0, CTRL, 8'h00);
    chk_val(q[1:0], 2'h2);
    bus(1, CTRL, 8'h00);
    for (int i = 0; i < 3; i++) begin
      // each target row sees far fewer than eight programs
      ta = 16'h7800 + 16'(i) * 16'h0100 + 16'(xs() >> 24);
      d = 8'(xs()) | 8'h01;
      // divider, select, protect read, target byte, hv
      bus(1, CTRL, 8'h41);
      bus(0, flpp_pkg::PROT_ADDR, 8'h00);
      bus(1, ta, d);
      bus(1, ta, ~d);
      chk_val(paddr, ta);
      chk_val({8'h00, pdat}, {8'h00, d});
      bus(1, CTRL, 8'h49);
      @(posedge clk);
      q[0] = pump;
      @(posedge clk);
      chk_val({15'h0, pump}, {15'h0, !q[0]});
      bus(1, CTRL, 8'h4D);
      bus(0, CTRL, 8'h00);
      chk_val(q[3:2], 2'h2);
      // hv off, margin on, select off, then verify read
      bus(1, CTRL, 8'h41);
      bus(1, CTRL, 8'h45);
      bus(0, 16'h1234, 8'h00);
      bus(1, CTRL, 8'h44);
      bus(0, ta, 8'h00);
      chk_val(q, d);
      // margin cleared after the verify read
      bus(1, CTRL, 8'h00);
    end
    bus(1, CTRL, 8'h01);
    bus(0, flpp_pkg::PROT_ADDR, 8'h00);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    bus(0, CTRL, 8'h00);
    chk_val(q, 8'h00);
    for (int b = 0; b < 4; b++) begin
      if (b > 0) try_prot(8'h01 << b, LO[b] - 16'h0001, 1'b0, 8'h01);
      try_prot(8'h01 << b, LO[b], 1'b0, 8'h01);
      try_prot(8'h01 << b, 16'hFFF5, 1'b0, 8'h01);
    end
    try_prot(8'h06, 16'h787F, 1'b0, 8'h01);
    try_prot(8'h06, 16'h7880, 1'b0, 8'h01);
    try_prot(8'h00, 16'h7E00 + 16'(xs() >> 24), 1'b0, 8'h01);
    try_prot(8'h08, 16'h79F8, 1'b0, 8'h32);
    try_prot(8'h08, 16'h79C8, 1'b0, 8'h22);
    try_prot(8'h08, 16'h7900, 1'b0, 8'h12);
    try_prot(8'h08, 16'h7800, 1'b0, 8'h02);
    tvh <= 1'b1;
    repeat (6) @(posedge clk);
    try_prot(8'h01, 16'h7FEE, 1'b1, 8'h01);
    try_prot(8'h0F, flpp_pkg::PROT_ADDR, 1'b1, 8'h01);
    summarize();
  end
endmodule // flash_program_protect_ctrl_tb_top
